// File: rtl/fba_map.svh
// Offsets, field positions, reset values and timing counts of the adapter block
// Assumes a 125 MHz system clock
`ifndef FBA_MAP_SVH
`define FBA_MAP_SVH
// ****************************************
// Clock and timing
// ****************************************
`define FBA_CLK_NS 8
`define FBA_CYC_MIN_NS 1000000
`define FBA_CYC_MIN_CYC ((`FBA_CYC_MIN_NS + `FBA_CLK_NS - 1) / `FBA_CLK_NS)
`define FBA_FLASH_HALF_NS 250000000
`define FBA_FLASH_HALF_CYC (`FBA_FLASH_HALF_NS / `FBA_CLK_NS)
// ****************************************
// Assemblies
// ****************************************
`define FBA_ASM_CLASS 8'h04
`define FBA_INST_OUT 8'h64
`define FBA_INST_IN 8'h65
`define FBA_OUT_WORDS 3'h2
`define FBA_IN_WORDS 3'h6
`define FBA_IN_BASE 3'h2
`define FBA_CMD_RUN 6
`define FBA_CMD_RST 7
`define FBA_CMD_MASK 16'h00c0
// ****************************************
// Register port
// ****************************************
`define FBA_REG_CTRL 8'h00
`define FBA_REG_ISTAT 8'h04
`define FBA_REG_IMASK 8'h08
`define FBA_REG_STAT 8'h0c
`define FBA_REG_NETCFG 8'h10
`define FBA_CTRL_OPCUA 0
`define FBA_CTRL_CFGRST 1
`define FBA_CTRL_RST 32'h00000001
`define FBA_NETCFG_RST 32'h00000000
`define FBA_EV_FWD 0
`define FBA_EV_NOLINK 1
`define FBA_EV_RSV 2
`define FBA_EV_GAP 3
`endif

// File: rtl/fba_pkg.sv
// Types shared by the adapter block
// Assumes nothing beyond the map header
package fba_pkg;
   typedef enum logic [0:0] {
      FBA_CMD_IDLE = 1'b0,
      FBA_CMD_EVAL = 1'b1
   } fba_cmd_st_t;
   typedef struct packed {
      logic valid;
      logic wr;
      logic expl;
      logic [7:0] inst;
      logic [2:0] word;
      logic [15:0] data;
   } fba_req_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] data;
   } fba_rsp_t;
   typedef struct packed {
      logic valid;
      logic run;
      logic trip_reset;
   } fba_cmd_t;
   typedef struct packed {
      logic [15:0] state;
      logic [31:0] current;
      logic [15:0] trip;
   } fba_sts_t;
   typedef struct packed {
      logic ip_ok;
      logic timeout;
      logic dup_ip;
      logic conn;
      logic [1:0] link;
      logic [1:0] act;
   } fba_net_t;
   typedef struct packed {
      logic power;
      logic err;
      logic status;
      logic [1:0] link;
      logic [1:0] act;
   } fba_led_t;
endpackage : fba_pkg

// File: rtl/fba_flash.sv
// Slow square wave for indicator flashing
// Assumes one clock and a clock enable
`timescale 1ns/100ps
module fba_flash #(
   parameter int unsigned HALF = 31250000
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   output logic flash
);
   typedef struct packed {
      logic [24:0] cnt;
      logic flash;
   } fba_fl_st_t;
   fba_fl_st_t s_ff;
   fba_fl_st_t nxt_s;
   always_comb begin
      nxt_s = s_ff;
      if (s_ff.cnt >= 25'(HALF - 1)) begin
         nxt_s.cnt = '0;
         nxt_s.flash = !s_ff.flash;
      end else begin
         nxt_s.cnt = s_ff.cnt + 25'h0000001;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '0;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end
   assign flash = s_ff.flash;
endmodule : fba_flash

// File: rtl/fba_asm_mem.sv
// Word store for both assemblies, registered read data
// Assumes one clock and a clock enable
`timescale 1ns/100ps
module fba_asm_mem #(
   parameter int unsigned W = 16,
   parameter int unsigned D = 8,
   parameter int unsigned AW = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } fba_mem_st_t;
   fba_mem_st_t s_ff;
   fba_mem_st_t nxt_s;
   always_comb begin
      nxt_s = s_ff;
      if (we) begin
         nxt_s.mem[waddr] = wdata;
      end
      if (re) begin
         nxt_s.rdata = s_ff.mem[raddr];
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '0;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end
   assign rdata = s_ff.rdata;
endmodule : fba_asm_mem

// File: rtl/fba_top.sv
// Adapter-side command and status logic of the fieldbus module
// Assumes scanner requests, starter status and network state come from clk logic;
// the network control enable link is a pin and is synchronised here
//
// What this block does
// - Output assembly 100, two words, four bytes
// - Input assembly 101, six words, twelve bytes
// - Serve cyclic and explicit requests
// - Forward commands only while link present
// - Hold command until overwritten or reset
// - Suppress repeated identical commands
// - Tool settings volatile, lost at reset
// - OPC UA enabled after configuration reset
// - Error indicator: timeout flashes, duplicate steady
// - Status indicator: flash addressed, steady connected
// - Link indicator lit while port connected
// - Activity indicator flashes during traffic
// - Cyclic gap one millisecond, little-endian
// - Bit 6 run, bit 7 reset edge
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "fba_map.svh"
module fba_top #(
   parameter int unsigned CYC_MIN = `FBA_CYC_MIN_CYC,
   parameter int unsigned FLASH_HALF = `FBA_FLASH_HALF_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   input wire fba_pkg::fba_req_t sc_req,
   output fba_pkg::fba_rsp_t sc_rsp,
   input wire logic network_control_enable_link,
   input wire fba_pkg::fba_sts_t st_sts,
   output fba_pkg::fba_cmd_t st_cmd,
   input wire fba_pkg::fba_net_t net,
   output fba_pkg::fba_led_t led,
   output logic opcua_en,
   output logic [31:0] net_cfg
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0] ena_sync;
      logic link_ok;
      fba_pkg::fba_cmd_st_t cst;
      logic [15:0] cmd_word;
      logic fwd_run;
      logic last_rst;
      fba_pkg::fba_cmd_t cmd;
      logic [19:0] gap;
      logic [2:0] ref_idx;
      logic p_valid;
      logic p_err;
      logic p_rd;
      fba_pkg::fba_rsp_t rsp;
      logic [3:0] istat;
      logic [3:0] imask;
      logic irq;
      logic opcua_en;
      logic [31:0] netcfg;
      logic [31:0] rdata;
      fba_pkg::fba_led_t led;
   } fba_top_st_t;
   fba_top_st_t s_ff;
   fba_top_st_t nxt_s;
   logic flash;
   logic [15:0] mem_rdata;
   logic mem_we;
   logic [2:0] mem_waddr;
   logic [15:0] mem_wdata;
   logic mem_re;
   logic [2:0] mem_raddr;
   logic [7:0] inst;
   logic out_sel;
   logic in_sel;
   logic bad_target;
   logic rsv_bad;
   logic too_soon;
   logic req_err;
   logic wr_ok;
   logic wr0;
   logic [3:0] ev;
   // ****************************************
   // Submodules
   // ****************************************
   fba_flash #(.HALF(FLASH_HALF)) u_flash (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .flash(flash)
   );
   fba_asm_mem #(.W(16), .D(8), .AW(3)) u_mem (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .re(mem_re),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );
   // ****************************************
   // Request decode
   // ****************************************
   always_comb begin
      if (sc_req.expl) begin
         inst = sc_req.inst;
      end else begin
         inst = sc_req.wr ? `FBA_INST_OUT : `FBA_INST_IN;
      end
      out_sel = (inst == `FBA_INST_OUT);
      in_sel = (inst == `FBA_INST_IN);
      bad_target = !(out_sel && sc_req.word < `FBA_OUT_WORDS)
         && !(in_sel && !sc_req.wr && sc_req.word < `FBA_IN_WORDS);
      rsv_bad = sc_req.wr && out_sel && (((sc_req.word == 3'h0) && ((sc_req.data & ~`FBA_CMD_MASK) != 16'h0000))
         || ((sc_req.word == 3'h1) && (sc_req.data != 16'h0000)));
      too_soon = sc_req.wr && !sc_req.expl && (sc_req.word == 3'h0) && (s_ff.gap < 20'(CYC_MIN));
      req_err = bad_target || rsv_bad || too_soon;
      wr_ok = sc_req.valid && sc_req.wr && !req_err;
      wr0 = wr_ok && (sc_req.word == 3'h0);
   end
   // ****************************************
   // Assembly store access
   // ****************************************
   always_comb begin
      mem_re = sc_req.valid && !sc_req.wr;
      mem_raddr = in_sel ? `FBA_IN_BASE + sc_req.word : sc_req.word;
      if (wr_ok) begin
         mem_we = 1'b1;
         mem_waddr = sc_req.word;
         mem_wdata = sc_req.data;
      end else begin
         mem_we = 1'b1;
         mem_waddr = `FBA_IN_BASE + s_ff.ref_idx;
         case (s_ff.ref_idx)
            3'h0: mem_wdata = st_sts.state;
            3'h2: mem_wdata = st_sts.current[15:0];
            3'h3: mem_wdata = st_sts.current[31:16];
            3'h4: mem_wdata = st_sts.trip;
            default: mem_wdata = 16'h0000;
         endcase
      end
   end
   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      ev = 4'h0;
      // Link pin synchroniser
      nxt_s.ena_sync = {s_ff.ena_sync[1:0], network_control_enable_link};
      if (s_ff.ena_sync[2] == s_ff.ena_sync[1]) begin
         nxt_s.link_ok = s_ff.ena_sync[2];
      end
      if (!wr_ok) begin
         nxt_s.ref_idx = (s_ff.ref_idx >= `FBA_IN_WORDS - 3'h1) ? 3'h0 : s_ff.ref_idx + 3'h1;
      end
      if (wr0 && !sc_req.expl) begin
         nxt_s.gap = '0;
      end else if (s_ff.gap < 20'(CYC_MIN)) begin
         nxt_s.gap = s_ff.gap + 20'h00001;
      end
      nxt_s.p_valid = sc_req.valid;
      nxt_s.p_err = sc_req.valid && req_err;
      nxt_s.p_rd = sc_req.valid && !sc_req.wr && !req_err;
      nxt_s.rsp.valid = s_ff.p_valid;
      nxt_s.rsp.err = s_ff.p_err;
      nxt_s.rsp.data = s_ff.p_rd ? mem_rdata : 16'h0000;
      if (sc_req.valid && rsv_bad) begin
         ev[`FBA_EV_RSV] = 1'b1;
      end
      if (sc_req.valid && too_soon) begin
         ev[`FBA_EV_GAP] = 1'b1;
      end
      // command word held until next accepted write to word 0
      nxt_s.cmd.valid = 1'b0;
      nxt_s.cmd.trip_reset = 1'b0;
      if (wr0) begin
         nxt_s.cmd_word = sc_req.data;
      end
      case (s_ff.cst)
         fba_pkg::FBA_CMD_IDLE: begin
            if (wr0) begin
               nxt_s.cst = fba_pkg::FBA_CMD_EVAL;
            end
         end
         fba_pkg::FBA_CMD_EVAL: begin
            nxt_s.cst = wr0 ? fba_pkg::FBA_CMD_EVAL : fba_pkg::FBA_CMD_IDLE;
            nxt_s.last_rst = s_ff.cmd_word[`FBA_CMD_RST];
            if (!s_ff.link_ok) begin
               ev[`FBA_EV_NOLINK] = 1'b1;
            // changed run or reset edge only
            end else if ((s_ff.cmd_word[`FBA_CMD_RUN] != s_ff.fwd_run)
               || (s_ff.cmd_word[`FBA_CMD_RST] && !s_ff.last_rst)) begin
               nxt_s.cmd.valid = 1'b1;
               nxt_s.cmd.run = s_ff.cmd_word[`FBA_CMD_RUN];
               nxt_s.cmd.trip_reset = s_ff.cmd_word[`FBA_CMD_RST] && !s_ff.last_rst;
               nxt_s.fwd_run = s_ff.cmd_word[`FBA_CMD_RUN];
               ev[`FBA_EV_FWD] = 1'b1;
            end
         end
         default: begin
            nxt_s.cst = fba_pkg::FBA_CMD_IDLE;
         end
      endcase
      // Register port
      nxt_s.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `FBA_REG_CTRL: nxt_s.rdata = {31'h00000000, s_ff.opcua_en};
            `FBA_REG_ISTAT: nxt_s.rdata = {28'h0000000, s_ff.istat};
            `FBA_REG_IMASK: nxt_s.rdata = {28'h0000000, s_ff.imask};
            `FBA_REG_STAT: nxt_s.rdata = {28'h0000000, s_ff.fwd_run, s_ff.cst, s_ff.cmd.run, s_ff.link_ok};
            `FBA_REG_NETCFG: nxt_s.rdata = s_ff.netcfg;
            default: nxt_s.rdata = 32'h00000000;
         endcase
      end
      if (reg_wr) begin
         case (reg_addr)
            `FBA_REG_CTRL: begin
               nxt_s.opcua_en = reg_wdata[`FBA_CTRL_OPCUA];
               if (reg_wdata[`FBA_CTRL_CFGRST]) begin
                  nxt_s.opcua_en = 1'(`FBA_CTRL_RST);
                  nxt_s.netcfg = `FBA_NETCFG_RST;
               end
            end
            `FBA_REG_ISTAT: nxt_s.istat = s_ff.istat & ~reg_wdata[3:0];
            `FBA_REG_IMASK: nxt_s.imask = reg_wdata[3:0];
            `FBA_REG_NETCFG: nxt_s.netcfg = reg_wdata;
            default: begin
            end
         endcase
      end
      // Set wins over clear
      nxt_s.istat = nxt_s.istat | ev;
      nxt_s.irq = |(s_ff.istat & s_ff.imask);
      // Indicators
      nxt_s.led.power = 1'b1;
      nxt_s.led.err = net.dup_ip || (net.timeout && flash);
      nxt_s.led.status = net.conn || (net.ip_ok && flash);
      for (int i = 0; i < 2; i++) begin
         nxt_s.led.link[i] = net.link[i];
         nxt_s.led.act[i] = net.act[i] && flash;
      end
   end
   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_ff <= '0;
         s_ff.opcua_en <= 1'b1;
         s_ff.gap <= '1;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end
   assign reg_rdata = s_ff.rdata;
   assign irq = s_ff.irq;
   assign sc_rsp = s_ff.rsp;
   assign st_cmd = s_ff.cmd;
   assign led = s_ff.led;
   assign opcua_en = s_ff.opcua_en;
   assign net_cfg = s_ff.netcfg;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_cmd_link_gate: assert property ($past(ce) && st_cmd.valid |-> $past(s_ff.link_ok))
      else $error("command forwarded without link");
   a_cmd_no_repeat: assert property ($past(ce) && st_cmd.valid && !st_cmd.trip_reset
      |-> st_cmd.run != $past(s_ff.fwd_run))
      else $error("identical command forwarded");
   a_cmd_word_held: assert property (ce && !wr0 |=> $stable(s_ff.cmd_word))
      else $error("command word changed without write");
   a_rsv_reject: assert property (ce && sc_req.valid && rsv_bad ##1 ce |=> sc_rsp.valid && sc_rsp.err)
      else $error("reserved bits accepted");
   a_gap_reject: assert property (ce && sc_req.valid && too_soon ##1 ce |=> sc_rsp.err)
      else $error("cyclic write too soon accepted");
   a_rsp_latency: assert property (ce && sc_req.valid ##1 ce |=> sc_rsp.valid)
      else $error("answer not two cycles after request");
   a_err_led_dup: assert property (ce && net.dup_ip |=> led.err)
      else $error("error indicator not steady");
   a_status_led: assert property (ce && net.conn |=> led.status)
      else $error("status indicator not steady");
   a_link_led: assert property (ce |=> led.link == $past(net.link))
      else $error("link indicator wrong");
   a_opcua_default: assert property (ce && reg_wr && reg_addr == `FBA_REG_CTRL
      && reg_wdata[`FBA_CTRL_CFGRST] |=> opcua_en)
      else $error("service not enabled after configuration reset");
   // ****************************************
   // Indicator, event and port checks
   // ****************************************
   a_cfg_reset_lost: assert property (ce && reg_wr && reg_addr == `FBA_REG_CTRL
      && reg_wdata[`FBA_CTRL_CFGRST] |=> net_cfg == 32'h00000000)
      else $error("tool settings kept after configuration reset");
   a_err_led_off: assert property (ce && !net.dup_ip && !net.timeout |=> !led.err)
      else $error("error indicator lit without fault");
   a_status_led_off: assert property (ce && !net.conn && !net.ip_ok |=> !led.status)
      else $error("status indicator lit without address");
   a_act_led_idle: assert property (ce |=> (led.act & ~$past(net.act)) == 2'b00)
      else $error("activity indicator lit without traffic");
   a_power_on: assert property (ce |=> led.power)
      else $error("power indicator dark");
   a_irq_level: assert property (ce |=> irq == |($past(s_ff.istat) & $past(s_ff.imask)))
      else $error("interrupt level wrong");
   a_refused_nostore: assert property (ce && sc_req.valid && sc_req.wr && req_err
      |-> !mem_we || mem_waddr >= `FBA_IN_BASE)
      else $error("refused write stored");
   a_link_gate_eval: assert property (ce && s_ff.cst == fba_pkg::FBA_CMD_EVAL && !s_ff.link_ok
      |=> !st_cmd.valid)
      else $error("command forwarded while link absent");
   a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data outside its cycle");
   a_no_req_no_rsp: assert property (ce && !sc_req.valid ##1 ce |=> !sc_rsp.valid)
      else $error("answer without request");
   a_trip_with_valid: assert property (st_cmd.trip_reset |-> st_cmd.valid)
      else $error("trip reset without command");
   a_fwd_event: assert property ($past(ce) && st_cmd.valid |-> s_ff.istat[`FBA_EV_FWD])
      else $error("forward event not recorded");
endmodule : fba_top

// File: verif/fba_scanner.sv
// Behavioural I/O scanner that issues assembly requests to the adapter
// Assumes one clock; each request is launched just after a rising edge
`timescale 1ns/100ps
module fba_scanner (
   input wire logic clk,
   output fba_pkg::fba_req_t sc_req,
   input wire fba_pkg::fba_rsp_t sc_rsp
);
   initial begin
      sc_req = '0;
   end
   // ****************************************
   // One request with its answer
   // ****************************************
   // scanner drives requests
   task automatic xfer(input logic wr, input logic expl, input logic [7:0] inst, input logic [2:0] word,
         input logic [15:0] data, output logic err, output logic [15:0] rdata, output logic ok);
      fba_pkg::fba_req_t r;
      r = '{valid: 1'b1, wr: wr, expl: expl, inst: inst, word: word, data: data};
      @(posedge clk);
      sc_req <= r;
      @(posedge clk);
      r.valid = 1'b0;
      r.inst = ~inst;
      r.data = ~data;
      sc_req <= r;
      @(posedge clk);
      #1;
      ok = sc_rsp.valid;
      err = sc_rsp.err;
      rdata = sc_rsp.data;
   endtask : xfer
endmodule : fba_scanner

// File: verif/fba_top_tb_top.sv
// Self-checking bench for the adapter command and status block
// Assumes the scanner model and design sources are compiled first
`timescale 1ns/100ps
`include "fba_map.svh"
module fba_top_tb_top;
   localparam int unsigned CYC = 20;
   logic clk;
   logic nrst;
   logic ce;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic irq;
   fba_pkg::fba_req_t sc_req;
   fba_pkg::fba_rsp_t sc_rsp;
   logic link;
   fba_pkg::fba_sts_t st_sts;
   fba_pkg::fba_cmd_t st_cmd;
   fba_pkg::fba_net_t net;
   fba_pkg::fba_led_t led;
   logic opcua_en;
   logic [31:0] net_cfg;
   int fails;
   int total_checks;
   int hi;
   int tog;
   logic [31:0] v;
   logic e;
   logic ok;
   logic [15:0] d;
   logic [15:0] exp_in [6] = '{16'h0105, 16'h0000, 16'h0d42, 16'h0001, 16'h0021, 16'h0000};
   // ****************************************
   // Clock, design and scanner
   // ****************************************
   initial begin
      clk = 1'b0;
   end
   always #4 clk = ~clk;
   fba_top #(.CYC_MIN(CYC), .FLASH_HALF(4)) i_dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .sc_req(sc_req), .sc_rsp(sc_rsp), .network_control_enable_link(link), .st_sts(st_sts),
      .st_cmd(st_cmd), .net(net), .led(led), .opcua_en(opcua_en), .net_cfg(net_cfg));
   fba_scanner i_scan (.clk(clk), .sc_req(sc_req), .sc_rsp(sc_rsp));
   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic reg_write(input logic [7:0] a, input logic [31:0] wv);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= wv;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_check(input logic [7:0] a, input logic [31:0] ev, input string msg);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, ev, msg);
   endtask : reg_check
   task automatic cmd(input logic [2:0] w, input logic [15:0] cv, input logic xe, input logic xv,
         input logic xr, input logic xt);
      i_scan.xfer(1'b1, 1'b1, 8'h64, w, cv, e, d, ok);
      chk({ok, e}, {1'b1, xe}, "command answer");
      chk({st_cmd.valid, st_cmd.trip_reset}, {xv, xt}, "command pulse");
      if (xv) begin
         chk(st_cmd.run, xr, "command run");
      end
   endtask : cmd
   task automatic rd_asm(input logic expl, input logic [7:0] inst, input logic [2:0] w, input logic xe,
         input logic [15:0] xd);
      i_scan.xfer(1'b0, expl, inst, w, 16'h0000, e, d, ok);
      chk({ok, e}, {1'b1, xe}, "read answer");
      if (!xe) begin
         chk(d, xd, "read data");
      end
   endtask : rd_asm
   task automatic nw(input logic [7:0] n, input int b);
      logic p;
      @(posedge clk);
      net <= n;
      hi = 0;
      tog = 0;
      @(posedge clk);
      #1;
      p = led[b];
      repeat (24) begin
         @(posedge clk);
         #1;
         hi += int'(led[b]);
         tog += int'(led[b] != p);
         p = led[b];
      end
   endtask : nw
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("wrong value at %0t ns: watchdog expired", $time);
      tally_and_finish();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      fails = 0;
      total_checks = 0;
      nrst = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      link = 1'b0;
      st_sts = '0;
      net = '0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      chk(opcua_en, 32'h1, "service enable after reset");
      reg_check(`FBA_REG_CTRL, 32'h1, "control reset");
      reg_check(`FBA_REG_NETCFG, 32'h0, "tool settings reset");
      reg_check(`FBA_REG_IMASK, 32'h0, "mask reset");
      reg_check(8'h20, 32'h0, "unmapped read");
      cmd(3'h0, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b0);
      reg_check(`FBA_REG_ISTAT, 32'h2, "refused without link");
      @(posedge clk);
      link <= 1'b1;
      repeat (5) @(posedge clk);
      cmd(3'h0, 16'h0040, 1'b0, 1'b1, 1'b1, 1'b0);
      cmd(3'h0, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b0);
      rd_asm(1'b1, 8'h64, 3'h0, 1'b0, 16'h0040);
      cmd(3'h0, 16'h00c0, 1'b0, 1'b1, 1'b1, 1'b1);
      cmd(3'h0, 16'h0080, 1'b0, 1'b1, 1'b0, 1'b0);
      reg_check(`FBA_REG_STAT, 32'h1, "status after command");
      cmd(3'h0, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b0);
      cmd(3'h1, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b0);
      cmd(3'h1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
      cmd(3'h2, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
      rd_asm(1'b1, 8'h64, 3'h0, 1'b0, 16'h0080);
      reg_check(`FBA_REG_ISTAT, 32'h7, "event status");
      reg_write(`FBA_REG_IMASK, 32'h1);
      @(posedge clk);
      #1;
      chk(irq, 32'h1, "interrupt raised");
      reg_write(`FBA_REG_ISTAT, 32'h1);
      @(posedge clk);
      #1;
      chk(irq, 32'h0, "interrupt cleared");
      reg_check(`FBA_REG_ISTAT, 32'h6, "write one clears");
      @(posedge clk);
      st_sts <= '{state: 16'h0105, current: 32'h00010d42, trip: 16'h0021};
      repeat (10) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rd_asm(1'b0, 8'h65, 3'(i), 1'b0, exp_in[i]);
      end
      rd_asm(1'b1, 8'h65, 3'h6, 1'b1, 16'h0000);
      cmd(3'h0, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
      i_scan.xfer(1'b1, 1'b1, 8'h65, 3'h0, 16'h0000, e, d, ok);
      chk({ok, e}, 32'h3, "input assembly write");
      i_scan.xfer(1'b1, 1'b0, 8'h64, 3'h0, 16'h0000, e, d, ok);
      chk({ok, e}, 32'h2, "first cyclic write");
      i_scan.xfer(1'b1, 1'b0, 8'h64, 3'h0, 16'h0000, e, d, ok);
      chk({ok, e}, 32'h3, "cyclic gap too short");
      reg_check(`FBA_REG_ISTAT, 32'he, "gap event");
      repeat (CYC) @(posedge clk);
      i_scan.xfer(1'b1, 1'b0, 8'h64, 3'h0, 16'h0000, e, d, ok);
      chk({ok, e}, 32'h2, "cyclic gap kept");
      reg_write(`FBA_REG_NETCFG, 32'ha5a55a5a);
      reg_check(`FBA_REG_NETCFG, 32'ha5a55a5a, "tool settings");
      reg_write(`FBA_REG_CTRL, 32'h0);
      reg_check(`FBA_REG_CTRL, 32'h0, "service off");
      chk(opcua_en, 32'h0, "service pin off");
      reg_write(`FBA_REG_CTRL, 32'h2);
      reg_check(`FBA_REG_CTRL, 32'h1, "configuration reset");
      chk(opcua_en, 32'h1, "service back on");
      chk(net_cfg, 32'h0, "settings lost");
      ce <= 1'b0;
      reg_write(`FBA_REG_NETCFG, 32'h0000ffff);
      @(posedge clk);
      ce <= 1'b1;
      reg_check(`FBA_REG_NETCFG, 32'h0, "frozen while disabled");
      nw(8'h00, 6);
      chk(hi, 32'd24, "power lamp");
      nw(8'h20, 5);
      chk(hi, 32'd24, "error steady on duplicate");
      nw(8'h40, 5);
      chk(tog >= 4, 32'h1, "error flashes on timeout");
      nw(8'h80, 5);
      chk(hi, 32'd0, "error off when addressed");
      nw(8'h80, 4);
      chk(tog >= 4, 32'h1, "status flashes");
      nw(8'h94, 4);
      chk(hi, 32'd24, "status steady");
      nw(8'h94, 2);
      chk(hi, 32'd24, "link lit");
      nw(8'h94, 3);
      chk(hi, 32'd0, "link dark");
      nw(8'h96, 1);
      chk(tog >= 4, 32'h1, "activity flashes");
      nw(8'h96, 0);
      chk(hi, 32'd0, "activity idle");
      tally_and_finish();
   end
endmodule : fba_top_tb_top
